//--- src/rgtc_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * receive gain and timing control block.
 * Assumes byte addressing on a 32-bit Avalon-MM slave port.
 */
`ifndef RGTC_PARAMS_SVH
`define RGTC_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define RGTC_GAIN_CFG_OFS 6'h00
`define RGTC_UPPER_OFS 6'h04
`define RGTC_FLOOR_OFS 6'h08
`define RGTC_TREC_OFS 6'h0c
`define RGTC_SSTH_OFS 6'h10
`define RGTC_CHBW_OFS 6'h14
`define RGTC_IFOFS_OFS 6'h18
`define RGTC_SYMPER_OFS 6'h1c
`define RGTC_STATUS_OFS 6'h20

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RGTC_F_EN 0
`define RGTC_F_FREEZE 1
`define RGTC_F_MEAS 8
`define RGTC_F_HOLD 16
`define RGTC_F_LOW0 16
`define RGTC_F_LOW1 20
`define RGTC_F_ORDER 0
`define RGTC_F_PFILT 1
`define RGTC_F_PFAST 4
`define RGTC_F_PSLOW 8
`define RGTC_F_IFAST 12
`define RGTC_F_ISLOW 16
`define RGTC_F_BWEXP 4
`define RGTC_F_IFDIG 8

// ------------------------------------------------------------
// Writable bit masks
// ------------------------------------------------------------
`define RGTC_GAIN_CFG_MSK 32'h003f_0f03
`define RGTC_UPPER_MSK 32'h0000_000f
`define RGTC_FLOOR_MSK 32'h00ff_01ff
`define RGTC_TREC_MSK 32'h0007_7773
`define RGTC_SSTH_MSK 32'h0000_00ff
`define RGTC_IFOFS_MSK 32'h0000_ffff
`define RGTC_SYMPER_MSK 32'h0000_ffff

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RGTC_GAIN_CFG_RST 32'h000c_0200
`define RGTC_UPPER_RST 32'h0000_0005
`define RGTC_FLOOR_RST 32'h0045_0010
`define RGTC_TREC_RST 32'h0003_3110
`define RGTC_SSTH_RST 32'h0000_0040
`define RGTC_CHBW_RST 32'h0000_0000
`define RGTC_IFOFS_RST 32'h0000_2a2a
`define RGTC_SYMPER_RST 32'h0000_0040

// ------------------------------------------------------------
// Gain and timing constants
// ------------------------------------------------------------
`define RGTC_AGC_UNIT_CYC 12
`define RGTC_STEP_DB 6
`define RGTC_MAX_STEP 4'h8
`define RGTC_MAX_MANT 4'h8
`define RGTC_MAX_EXP 4'h9
`define RGTC_FREQ_SHIFT 4'h4

`endif

//--- src/rgtc_pkg.sv
/*
 * Types of the receive gain and timing control block.
 * Assumes rgtc_params.svh supplies all numeric constants.
 */
package rgtc_pkg;

   // Gain loop states
   typedef enum logic [1:0] {
      RGTC_MON = 2'b00,
      RGTC_MEAS = 2'b01,
      RGTC_HOLD = 2'b10
   } rgtc_agc_state_t;

   // Gain loop configuration
   typedef struct packed {
      logic [5:0] hold;
      logic [3:0] meas;
      logic freeze;
      logic en;
   } rgtc_agc_cfg_t;

   // Timing loop configuration
   typedef struct packed {
      logic [2:0] islow;
      logic [2:0] ifast;
      logic [2:0] pslow;
      logic [2:0] pfast;
      logic pfilt;
      logic order;
   } rgtc_tmr_cfg_t;

endpackage : rgtc_pkg

//--- src/rgtc_top.sv
/*
 * Receive gain control, symbol timing recovery, channel filter
 * word and IF offset registers behind an Avalon-MM slave.
 * Assumes amplitude, sync, edge and signal strength inputs come
 * from datapath logic on mclk, so none is synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rgtc_params.svh"

module rgtc_top
   import rgtc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [3:0] peak_amp,
   input wire logic peak_valid,
   input wire logic sync_found,
   input wire logic rx_start,
   input wire logic [7:0] signal_strength,
   input wire logic rx_edge,
   output logic [3:0] atten_step,
   output logic [5:0] atten_db,
   output logic post_filter_long,
   output logic [3:0] chan_bw_mant,
   output logic [3:0] chan_bw_exp,
   output logic [7:0] analog_if_offset,
   output logic [7:0] digital_if_offset,
   output logic symbol_strobe,
   output logic timing_active
);

   // ---------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------

   // Byte lane merge for partial writes
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_w,
      input logic [31:0] new_w,
      input logic [3:0] be,
      input logic [31:0] msk
   );
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r & msk;
   endfunction : be_merge

   // Step count to attenuation in dB
   function automatic logic [5:0] step_db(input logic [3:0] s);
      return 6'(s * `RGTC_STEP_DB);
   endfunction : step_db

   // ---------------------------------------------------------
   // Register storage and bus slave
   // ---------------------------------------------------------
   logic [31:0] r_gain;
   logic [31:0] r_upper;
   logic [31:0] r_floor;
   logic [31:0] r_trec;
   logic [31:0] r_ssth;
   logic [31:0] r_chbw;
   logic [31:0] r_ifofs;
   logic [31:0] r_symper;
   logic [31:0] rd_word;
   logic [31:0] bw_word;
   logic wr_go;
   logic frozen;
   logic synced;
   rgtc_agc_state_t agc_state;
   rgtc_agc_cfg_t acfg;
   rgtc_tmr_cfg_t tcfg;

   // Write lands on the edge where waitrequest is seen low
   assign wr_go = write && !waitrequest;

   // One wait cycle, then the answer for one cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
      end else if ((read || write) && waitrequest) begin
         waitrequest <= 1'b0;
         if (read) begin
            readdata <= rd_word;
         end
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // Read decode; unmapped words read zero
   always_comb begin
      unique case (address)
         `RGTC_GAIN_CFG_OFS: rd_word = r_gain;
         `RGTC_UPPER_OFS: rd_word = r_upper;
         `RGTC_FLOOR_OFS: rd_word = r_floor;
         `RGTC_TREC_OFS: rd_word = r_trec;
         `RGTC_SSTH_OFS: rd_word = r_ssth;
         `RGTC_CHBW_OFS: rd_word = r_chbw;
         `RGTC_IFOFS_OFS: rd_word = r_ifofs;
         `RGTC_SYMPER_OFS: rd_word = r_symper;
         `RGTC_STATUS_OFS: rd_word = {17'h0_0000, frozen, synced,
            timing_active, agc_state, atten_db, atten_step};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Bandwidth word clamped into the table so a bad code never runs
   always_comb begin
      bw_word = be_merge(r_chbw, writedata, byteenable, 32'h0000_00ff);
      if (bw_word[3:0] > `RGTC_MAX_MANT) begin
         bw_word[3:0] = `RGTC_MAX_MANT;
      end
      if (bw_word[7:4] > `RGTC_MAX_EXP) begin
         bw_word[7:4] = `RGTC_MAX_EXP;
      end
   end

   // Configuration registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r_gain <= `RGTC_GAIN_CFG_RST;
         r_upper <= `RGTC_UPPER_RST;
         r_floor <= `RGTC_FLOOR_RST;
         r_trec <= `RGTC_TREC_RST;
         r_ssth <= `RGTC_SSTH_RST;
         r_chbw <= `RGTC_CHBW_RST;
         r_ifofs <= `RGTC_IFOFS_RST;
         r_symper <= `RGTC_SYMPER_RST;
      end else if (wr_go) begin
         unique case (address)
            `RGTC_GAIN_CFG_OFS: r_gain <= be_merge(r_gain, writedata,
               byteenable, `RGTC_GAIN_CFG_MSK);
            `RGTC_UPPER_OFS: r_upper <= be_merge(r_upper, writedata,
               byteenable, `RGTC_UPPER_MSK);
            `RGTC_FLOOR_OFS: r_floor <= be_merge(r_floor, writedata,
               byteenable, `RGTC_FLOOR_MSK);
            `RGTC_TREC_OFS: r_trec <= be_merge(r_trec, writedata,
               byteenable, `RGTC_TREC_MSK);
            `RGTC_SSTH_OFS: r_ssth <= be_merge(r_ssth, writedata,
               byteenable, `RGTC_SSTH_MSK);
            `RGTC_CHBW_OFS: r_chbw <= bw_word;
            `RGTC_IFOFS_OFS: r_ifofs <= be_merge(r_ifofs, writedata,
               byteenable, `RGTC_IFOFS_MSK);
            `RGTC_SYMPER_OFS: r_symper <= be_merge(r_symper, writedata,
               byteenable, `RGTC_SYMPER_MSK);
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------
   // Static outputs to the analog chain and datapath
   // ---------------------------------------------------------
   // Table values scale with mclk over 26 MHz; nothing to compute
   assign chan_bw_mant = r_chbw[3:0];
   assign chan_bw_exp = r_chbw[`RGTC_F_BWEXP +: 4];
   assign analog_if_offset = r_ifofs[7:0];
   assign digital_if_offset = r_ifofs[`RGTC_F_IFDIG +: 8];
   assign post_filter_long = r_trec[`RGTC_F_PFILT];

   assign acfg = '{hold: r_gain[`RGTC_F_HOLD +: 6],
                   meas: r_gain[`RGTC_F_MEAS +: 4],
                   freeze: r_gain[`RGTC_F_FREEZE],
                   en: r_gain[`RGTC_F_EN]};
   // Fields sit on nibble boundaries, so a plain cast would misalign them
   assign tcfg = '{islow: r_trec[`RGTC_F_ISLOW +: 3], ifast: r_trec[`RGTC_F_IFAST +: 3],
                   pslow: r_trec[`RGTC_F_PSLOW +: 3], pfast: r_trec[`RGTC_F_PFAST +: 3],
                   pfilt: r_trec[`RGTC_F_PFILT], order: r_trec[`RGTC_F_ORDER]};

   // ---------------------------------------------------------
   // Gain controller
   // ---------------------------------------------------------
   logic [3:0] high_thr;
   logic [3:0] low_thr;
   logic [18:0] meas_cyc;
   logic [18:0] hold_cyc;
   logic [18:0] agc_cnt;

   // Floor picked by the bit belonging to the current step
   assign low_thr = r_floor[atten_step] ? r_floor[`RGTC_F_LOW1 +: 4]
                                        : r_floor[`RGTC_F_LOW0 +: 4];
   assign high_thr = r_upper[3:0];
   assign meas_cyc = 19'(`RGTC_AGC_UNIT_CYC) << acfg.meas;
   assign hold_cyc = 19'(`RGTC_AGC_UNIT_CYC * acfg.hold);

   // Freeze latch; a sync in the clearing cycle still freezes
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frozen <= 1'b0;
      end else if (sync_found && acfg.freeze && acfg.en) begin
         frozen <= 1'b1;
      end else if (rx_start || !acfg.freeze) begin
         frozen <= 1'b0;
      end
   end

   // Step loop: up per hold, down after a full quiet measure
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         agc_state <= RGTC_MON;
         agc_cnt <= 19'h0_0000;
         atten_step <= 4'h0;
         atten_db <= 6'h00;
      end else if (!acfg.en) begin
         agc_state <= RGTC_MON;
         agc_cnt <= 19'h0_0000;
      end else begin
         unique case (agc_state)
            RGTC_MON: begin
               if (!frozen && peak_valid) begin
                  if (peak_amp > high_thr) begin
                     if (atten_step < `RGTC_MAX_STEP) begin
                        atten_step <= atten_step + 4'h1;
                        atten_db <= step_db(atten_step + 4'h1);
                     end
                     agc_state <= RGTC_HOLD;
                     agc_cnt <= hold_cyc;
                  end else if (peak_amp < low_thr) begin
                     agc_state <= RGTC_MEAS;
                     agc_cnt <= meas_cyc;
                  end
                  // In band: no change, keep watching
               end
            end
            RGTC_MEAS: begin
               // Any sample at or above the floor restarts the watch
               if (frozen || (peak_valid && peak_amp >= low_thr)) begin
                  agc_state <= RGTC_MON;
               end else if (agc_cnt <= 19'h0_0001) begin
                  if (atten_step != 4'h0) begin
                     atten_step <= atten_step - 4'h1;
                     atten_db <= step_db(atten_step - 4'h1);
                  end
                  agc_state <= RGTC_HOLD;
                  agc_cnt <= hold_cyc;
               end else begin
                  agc_cnt <= agc_cnt - 19'h0_0001;
               end
            end
            RGTC_HOLD: begin
               // Zero hold still waits one cycle
               if (agc_cnt <= 19'h0_0001) begin
                  agc_state <= RGTC_MON;
               end else begin
                  agc_cnt <= agc_cnt - 19'h0_0001;
               end
            end
            default: agc_state <= RGTC_MON;
         endcase
      end
   end

   // ---------------------------------------------------------
   // Symbol timing recovery
   // ---------------------------------------------------------
   logic [15:0] phase;
   logic signed [17:0] freq_corr;
   logic signed [17:0] phase_err;
   logic signed [17:0] per_eff;
   logic signed [17:0] ph_adj;
   logic [2:0] kp;
   logic [3:0] ki_sh;

   // Sync latch selects gain set; a sync wins over a restart
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         synced <= 1'b0;
      end else if (sync_found) begin
         synced <= 1'b1;
      end else if (rx_start) begin
         synced <= 1'b0;
      end
   end

   // Loop runs once the signal is strong enough
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timing_active <= 1'b0;
      end else begin
         timing_active <= (signal_strength > r_ssth[7:0]) ||
                          (timing_active && !rx_start);
      end
   end

   assign kp = synced ? tcfg.pslow : tcfg.pfast;
   assign ki_sh = (synced ? {1'b0, tcfg.islow} : {1'b0, tcfg.ifast})
                  + `RGTC_FREQ_SHIFT;
   // Error against mid-symbol, where an edge should fall
   assign phase_err = $signed({2'b00, phase}) -
                      $signed({3'b000, r_symper[15:1]});
   assign per_eff = $signed({2'b00, r_symper[15:0]}) + freq_corr;
   // Smaller gain code shifts less, so corrects faster
   assign ph_adj = $signed({2'b00, phase}) - (phase_err >>> kp);

   // Local bit-timing generator with delay and frequency trim
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         phase <= 16'h0000;
         freq_corr <= 18'sh0_0000;
         symbol_strobe <= 1'b0;
      end else if (!timing_active) begin
         phase <= 16'h0000;
         freq_corr <= 18'sh0_0000;
         symbol_strobe <= 1'b0;
      end else begin
         symbol_strobe <= 1'b0;
         if (rx_edge) begin
            phase <= ph_adj[17] ? 16'h0000 : ph_adj[15:0];
            if (tcfg.order) begin
               freq_corr <= freq_corr + (phase_err >>> ki_sh);
            end else begin
               freq_corr <= 18'sh0_0000;
            end
         end else if ($signed({2'b00, phase}) + 18'sh0_0001 >= per_eff) begin
            phase <= 16'h0000;
            symbol_strobe <= 1'b1;
         end else begin
            phase <= phase + 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   step_ceiling_a: assert property (@(posedge mclk) disable iff (!nrst)
      atten_step <= `RGTC_MAX_STEP && atten_db == step_db(atten_step))
      else $error("attenuation step out of range");

   raise_step_a: assert property (@(posedge mclk) disable iff (!nrst)
      (acfg.en && agc_state == RGTC_MON && !frozen && peak_valid &&
       peak_amp > high_thr && atten_step < `RGTC_MAX_STEP)
      |=> atten_step == $past(atten_step) + 4'h1 && agc_state == RGTC_HOLD)
      else $error("high amplitude did not raise attenuation");

   lower_only_a: assert property (@(posedge mclk) disable iff (!nrst)
      (atten_step < $past(atten_step)) |-> $past(agc_state) == RGTC_MEAS)
      else $error("attenuation fell outside a measure end");

   meas_load_a: assert property (@(posedge mclk) disable iff (!nrst)
      (agc_state == RGTC_MEAS && $past(agc_state) == RGTC_MON)
      |-> agc_cnt == 19'(12) << $past(acfg.meas))
      else $error("measure interval length wrong");

   hold_load_a: assert property (@(posedge mclk) disable iff (!nrst)
      (agc_state == RGTC_HOLD && $past(agc_state) != RGTC_HOLD)
      |-> agc_cnt == 19'(12 * $past(acfg.hold)))
      else $error("hold interval length wrong");

   freeze_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      (frozen && agc_state == RGTC_MON) |=> $stable(atten_step))
      else $error("attenuation moved while frozen");

   band_still_a: assert property (@(posedge mclk) disable iff (!nrst)
      (agc_state == RGTC_MON && peak_valid && peak_amp <= high_thr &&
       peak_amp >= low_thr) |=> $stable(atten_step) && agc_state == RGTC_MON)
      else $error("in-band amplitude changed attenuation");

   delay_only_a: assert property (@(posedge mclk) disable iff (!nrst)
      (timing_active && !tcfg.order && rx_edge) |=> freq_corr == 18'sh0_0000)
      else $error("first order loop touched frequency");

   start_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
      !timing_active |=> phase == 16'h0000 && !symbol_strobe)
      else $error("timing ran below strength threshold");

   bw_range_a: assert property (@(posedge mclk) disable iff (!nrst)
      chan_bw_mant <= `RGTC_MAX_MANT && chan_bw_exp <= `RGTC_MAX_EXP)
      else $error("bandwidth code outside table");

   bus_ack_a: assert property (@(posedge mclk) disable iff (!nrst)
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle after request");

endmodule : rgtc_top
`default_nettype wire

//--- testbench/rgtc_rf_model.sv
/*
 * RF attenuator chain and demodulator model: peak amplitude is the
 * incoming level less one unit per attenuation step.
 * Assumes the bench sets the level and one mclk domain.
 */
`timescale 1ns/1ns
`default_nettype none
module rgtc_rf_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [4:0] level,
   input wire logic edge_on,
   input wire logic [3:0] atten_step,
   output logic [3:0] peak_amp,
   output logic peak_valid,
   output logic rx_edge
);
   logic [4:0] cnt;
   logic [4:0] amp;

   // Loss per step; clamp keeps the 4-bit sample from wrapping
   always_comb begin
      amp = (level > {1'b0, atten_step}) ? level - {1'b0, atten_step} : 5'h00;
   end

   // One sample a cycle, a data edge every 32 cycles when enabled
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         peak_amp <= 4'h0;
         peak_valid <= 1'b0;
         rx_edge <= 1'b0;
         cnt <= 5'h00;
      end else begin
         peak_amp <= amp[4] ? 4'hf : amp[3:0];
         peak_valid <= 1'b1;
         cnt <= cnt + 5'h01;
         rx_edge <= edge_on && (cnt == 5'h00);
      end
   end
endmodule : rgtc_rf_model
`default_nettype wire

//--- testbench/tb_top.sv
/*
 * Self-checking bench of the gain and timing control block.
 * Assumes the Avalon answer comes on its own and one 250 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rgtc_params.svh"
module tb_top;
   logic mclk, nrst, read, write, peak_valid, sync_found, rx_start, rx_edge, edge_on, waitrequest;
   logic post_filter_long, symbol_strobe, timing_active;
   logic [5:0] address, atten_db;
   logic [31:0] writedata, readdata, q;
   logic [3:0] byteenable, peak_amp, atten_step, chan_bw_mant, chan_bw_exp;
   logic [7:0] signal_strength, analog_if_offset, digital_if_offset;
   logic [4:0] level;
   int err_total, tests_run, n;
   localparam logic [5:0] OFS [9] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h24};
   localparam logic [31:0] RV [9] = '{`RGTC_GAIN_CFG_RST, `RGTC_UPPER_RST, `RGTC_FLOOR_RST,
      `RGTC_TREC_RST, `RGTC_SSTH_RST, `RGTC_CHBW_RST, `RGTC_IFOFS_RST, `RGTC_SYMPER_RST, 32'h0};

   rgtc_top uut (.mclk(mclk), .nrst(nrst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .peak_amp(peak_amp), .peak_valid(peak_valid), .sync_found(sync_found), .rx_start(rx_start),
      .signal_strength(signal_strength), .rx_edge(rx_edge), .atten_step(atten_step),
      .atten_db(atten_db), .post_filter_long(post_filter_long), .chan_bw_mant(chan_bw_mant),
      .chan_bw_exp(chan_bw_exp), .analog_if_offset(analog_if_offset),
      .digital_if_offset(digital_if_offset), .symbol_strobe(symbol_strobe), .timing_active(timing_active));
   rgtc_rf_model rf (.mclk(mclk), .nrst(nrst), .level(level), .edge_on(edge_on),
      .atten_step(atten_step), .peak_amp(peak_amp), .peak_valid(peak_valid), .rx_edge(rx_edge));

   // -----------------------------
   // Helpers
   // -----------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Range compare for measured intervals
   task chk_rng(input string nm, input int lo, input int hi, input int g);
      tests_run++;
      if (g < lo || g > hi) begin
         err_total++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : chk_rng
   // Request held until waitrequest is seen low at an edge
   task xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (waitrequest !== 1'b0 && k < 100);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : xfer
   task run(input int c);
      repeat (c) @(posedge mclk);
   endtask : run
   // Cycles until the attenuation step moves
   task gap();
      logic [3:0] s;
      s = atten_step;
      n = 0;
      while (atten_step === s && n < 2000) begin
         @(posedge mclk);
         n++;
      end
   endtask : gap
   task strobe_gap();
      n = 0;
      while (symbol_strobe !== 1'b1 && n < 200) begin
         @(posedge mclk);
         n++;
      end
   endtask : strobe_gap
   task pulse(input bit syn);
      @(posedge mclk);
      if (syn) sync_found <= 1'b1;
      else rx_start <= 1'b1;
      @(posedge mclk);
      sync_found <= 1'b0;
      rx_start <= 1'b0;
   endtask : pulse

   // -----------------------------
   // Scenarios
   // -----------------------------
   task t_regs();
      chk("timing idle", 0, timing_active);
      for (int i = 0; i < 9; i++) begin
         xfer(0, OFS[i], 0);
         chk("reset value", RV[i], q);
      end
      xfer(1, 6'h04, 32'hffff_ffff);
      xfer(0, 6'h04, 0);
      chk("high threshold", 32'h0000_000f, q);
      xfer(1, 6'h04, 32'h0000_0005);
   endtask : t_regs
   task t_timing();
      xfer(1, 6'h1c, 32'h0000_0010);
      signal_strength <= 8'h41;
      run(3);
      chk("timing on", 1, timing_active);
      strobe_gap();
      run(1);
      strobe_gap();
      chk_rng("symbol period", 15, 17, n + 1);
      xfer(1, 6'h0c, 32'h0003_3111);
      edge_on <= 1'b1;
      run(200);
      strobe_gap();
      chk_rng("pll strobe", 0, 30, n);
      xfer(1, 6'h0c, 32'h0003_3110);
      run(100);
      strobe_gap();
      chk_rng("dll strobe", 0, 30, n);
      signal_strength <= 8'h40;
      pulse(0);
      run(3);
      chk("timing off", 0, timing_active);
   endtask : t_timing
   task t_chan();
      xfer(1, 6'h14, 32'h0000_00ff);
      xfer(1, 6'h18, 32'h0000_1234);
      xfer(1, 6'h0c, 32'h0003_3113);
      run(1);
      chk("bw mant", 8, chan_bw_mant);
      chk("bw exp", 9, chan_bw_exp);
      chk("if ana", 8'h34, analog_if_offset);
      chk("if dig", 8'h12, digital_if_offset);
      chk("post filter", 1, post_filter_long);
   endtask : t_chan
   task t_high();
      xfer(1, 6'h00, 32'h0001_0001);
      level <= 5'd10;
      gap();
      gap();
      chk_rng("up interval", 12, 14, n);
      run(300);
      chk("settled step", 5, atten_step);
      chk("settled db", 30, atten_db);
      level <= 5'd20;
      run(300);
      chk("max step", 8, atten_step);
      chk("max db", 48, atten_db);
   endtask : t_high
   task t_low();
      xfer(1, 6'h00, 32'h0001_0101);
      level <= 5'd0;
      gap();
      gap();
      chk_rng("down interval", 36, 40, n);
      run(600);
      chk("min step", 0, atten_step);
   endtask : t_low
   task t_floor_freeze();
      level <= 5'd10;
      run(300);
      level <= 5'd8;
      run(400);
      chk("floor select", 4, atten_step);
      xfer(1, 6'h00, 32'h0001_0103);
      pulse(1);
      level <= 5'd20;
      run(200);
      chk("frozen", 4, atten_step);
      xfer(0, 6'h20, 0);
      chk("status word", 32'h0000_6184, q);
      pulse(0);
      run(300);
      chk("unfrozen", 8, atten_step);
   endtask : t_floor_freeze
   // Reset in mid-run must drop the step and reload registers
   task t_reset();
      nrst <= 1'b0;
      run(2);
      nrst <= 1'b1;
      run(1);
      chk("reset step", 0, atten_step);
      xfer(0, 6'h00, 0);
      chk("reset gain cfg", `RGTC_GAIN_CFG_RST, q);
   endtask : t_reset

   task stop_test();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   // Clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      #100000;
      err_total++;
      stop_test();
   end
   // Main sequence
   initial begin
      {nrst, read, write, sync_found, rx_start, edge_on} = 6'h0;
      {address, writedata, byteenable, signal_strength, level} = '0;
      byteenable = 4'hf;
      err_total = 0;
      tests_run = 0;
      run(16);
      nrst <= 1'b1;
      t_regs();
      t_timing();
      t_chan();
      t_high();
      t_low();
      t_floor_freeze();
      t_reset();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
